//--- alsr_consts.svh
// Purpose: Offsets, field positions, reset values and counts for the alarm status register
// Assumes: Included by the design modules
// Notes: Guarded against double inclusion
// How it works
// - Flag sets after N consecutive out-of-range checks
// - In-range before N keeps flag at zero
// - Latched flag holds until read, cause gone or not
// - Latched flag clears only by read or reset
// - Read clears flags; persisting cause resets them
// - Hold disabled: flag follows condition directly
// - Sixteen bit read-only register at 4Fh, resets zero
// - Bit 15 reads zero, writes ignored
// - Bit 14 flags input 0 or pair 0/1
// - Bit 13 flags input 1 out of range
// - Bit 12 flags input 2 or pair 2/3
// - Bit 11 flags input 3 out of range
// - Bit 10 on-chip under, only when enabled
// - Bit 9 on-chip over, only when enabled
// - Bit 8 remote one under, when enabled
// - Bit 7 remote one over, when enabled
// - Bit 6 remote two under, when enabled
// - Bit 5 remote two over, when enabled
// - Bits 4,3 remote sensor faults, when enabled
// - Bit 2 die at least 150C, 8C hysteresis
// - Masked alarms set flag but not pin
`ifndef ALSR_CONSTS_SVH
`define ALSR_CONSTS_SVH

`define ALSR_ADDR_STATUS 8'h4F
`define ALSR_ADDR_CTRL 8'h4E
`define ALSR_ADDR_MASK 8'h4D
`define ALSR_RESET_VALUE 16'h0000
`define ALSR_BIT_CH0 14
`define ALSR_BIT_CH1 13
`define ALSR_BIT_CH2 12
`define ALSR_BIT_CH3 11
`define ALSR_BIT_LT_LO 10
`define ALSR_BIT_LT_HI 9
`define ALSR_BIT_R1_LO 8
`define ALSR_BIT_R1_HI 7
`define ALSR_BIT_R2_LO 6
`define ALSR_BIT_R2_HI 5
`define ALSR_BIT_R1_FAIL 4
`define ALSR_BIT_R2_FAIL 3
`define ALSR_BIT_THERM 2
`define ALSR_LIVE_MASK 16'h7FFC
`define ALSR_CTRL_HOLD_DIS 0
`define ALSR_CTRL_ONCHIP_SENSOR_ENABLE 1
`define ALSR_CTRL_EN_R1 2
`define ALSR_CTRL_EN_R2 3
`define ALSR_CTRL_RESET 16'h0000
`define ALSR_MASK_RESET 16'h0000
`define ALSR_CONSEC_N 4
`define ALSR_THERM_TRIP 16'h0960
`define ALSR_THERM_HYST 16'h0080

`endif

//--- alsr_pkg.sv
// Purpose: Types for the alarm status register block
// Assumes: alsr_consts.svh holds the numbers
// Notes: Types only
package alsr_pkg;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } alsr_req_s;

  // One completed conversion cycle
  typedef struct packed {
    logic done;
    logic [13:0] over_range;
    logic [15:0] die_temp;
  } alsr_conv_s;

  typedef enum logic [1:0] {
    ALSR_ST_CLEAR = 2'b00,
    ALSR_ST_COUNT = 2'b01,
    ALSR_ST_SET = 2'b10
  } alsr_flag_e;
endpackage

//--- alsr_flag_cell.sv
// Purpose: One alarm flag with consecutive-result filter and hold logic
// Assumes: check strobes once per completed conversion cycle
// Notes: Set from a filtered condition wins over a clearing read
`timescale 1ns/1ns
`include "alsr_consts.svh"
module alsr_flag_cell
  import alsr_pkg::*;
#(
  parameter int CONSEC_N = `ALSR_CONSEC_N
)
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable
  input wire logic check, // Conversion cycle done
  input wire logic out_of_range, // Raw condition this cycle
  input wire logic enable, // Channel evaluated
  input wire logic hold_dis, // Flag follows condition
  input wire logic read_clr, // Status register read
  output logic flag // Status flag
);
  localparam int CW = $clog2(CONSEC_N + 1);
  logic [CW-1:0] cnt_q;
  logic cond_q;
  alsr_flag_e st_q;
  logic hit;

  assign hit = check && enable && out_of_range;

  ////////////////////////////////////////////////////////////////
  // Consecutive filter: any in-range result restarts the count
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      cond_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!enable)
      begin
        cnt_q <= '0;
        cond_q <= 1'b0;
      end
      else if (check)
      begin
        if (!out_of_range)
        begin
          cnt_q <= '0;
          cond_q <= 1'b0;
        end
        else if (cnt_q >= CW'(CONSEC_N - 1))
        begin
          cnt_q <= CW'(CONSEC_N);
          cond_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flag state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st_q <= ALSR_ST_CLEAR;
    else if (ce)
    begin
      case (st_q)
        ALSR_ST_CLEAR:
        begin
          if (hit && cond_q)
            st_q <= ALSR_ST_SET;
          else if (hit)
            st_q <= ALSR_ST_COUNT;
        end
        ALSR_ST_COUNT:
        begin
          if (!enable || (check && !out_of_range))
            st_q <= ALSR_ST_CLEAR;
          else if (hit && cnt_q >= CW'(CONSEC_N - 1))
            st_q <= ALSR_ST_SET;
        end
        ALSR_ST_SET:
        begin
          if (hold_dis && !cond_q)
            st_q <= ALSR_ST_CLEAR;
          else if (read_clr && !(hit && cnt_q >= CW'(CONSEC_N - 1)))
            st_q <= cond_q ? ALSR_ST_COUNT : ALSR_ST_CLEAR;
        end
        default: st_q <= ALSR_ST_CLEAR;
      endcase
    end
  end

  // Immediate clear when hold is disabled and the condition is gone
  assign flag = (st_q == ALSR_ST_SET) && !(hold_dis && !cond_q);
endmodule // alsr_flag_cell

//--- alsr_status.sv
// Purpose: Alarm status register with filtered, held alarm flags and alarm pin
// Assumes: Converter logic gives per-channel out-of-range results and a done strobe
// Notes: Control and mask registers sit beside the status word on the same port
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`include "alsr_consts.svh"
module alsr_status
  import alsr_pkg::*;
#(
  parameter int CONSEC_N = `ALSR_CONSEC_N
)
(
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic soft_rst, // Software reset pulse
  input wire alsr_req_s req, // Register port request
  input wire alsr_conv_s conv, // Conversion results
  input wire logic remote1_fail, // Remote one open or short
  input wire logic remote2_fail, // Remote two open or short
  output logic [15:0] rdata, // Read data, cycle after read
  output logic alarm_n // Alarm output, low when active
);
  logic [15:0] ctrl_q;
  logic [15:0] mask_q;
  logic [15:0] rdata_q;
  logic alarm_n_q;
  logic therm_q;
  logic read_clr;
  logic [15:0] cond;
  logic [15:0] en_vec;
  logic [15:0] flags;
  logic any_rst;
  logic hold_dis;

  assign any_rst = rst || soft_rst;
  assign hold_dis = ctrl_q[`ALSR_CTRL_HOLD_DIS];
  assign read_clr = ce && req.rd && (req.addr == `ALSR_ADDR_STATUS);

  ////////////////////////////////////////////////////////////////
  // Writable control and mask; status word takes no writes
  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
    begin
      ctrl_q <= `ALSR_CTRL_RESET;
      mask_q <= `ALSR_MASK_RESET;
    end
    else if (ce && req.wr)
    begin
      if (req.addr == `ALSR_ADDR_CTRL)
        ctrl_q <= req.wdata & 16'h000F;
      else if (req.addr == `ALSR_ADDR_MASK)
        mask_q <= req.wdata & `ALSR_LIVE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Die temperature trip with hysteresis, forced low while sensor off
  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
      therm_q <= 1'b0;
    else if (ce)
    begin
      if (!ctrl_q[`ALSR_CTRL_ONCHIP_SENSOR_ENABLE])
        therm_q <= 1'b0;
      else if (conv.done)
      begin
        if (conv.die_temp >= `ALSR_THERM_TRIP)
          therm_q <= 1'b1;
        else if (conv.die_temp < (`ALSR_THERM_TRIP - `ALSR_THERM_HYST))
          therm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Raw conditions and enables per status bit
  always_comb
  begin
    cond = '0;
    en_vec = '0;
    cond[14:5] = conv.over_range[13:4];
    cond[`ALSR_BIT_R1_FAIL] = remote1_fail;
    cond[`ALSR_BIT_R2_FAIL] = remote2_fail;
    // Decided on this very result, so the filter counts the same done that measured it
    if (therm_q)
      cond[`ALSR_BIT_THERM] = (conv.die_temp >= (`ALSR_THERM_TRIP - `ALSR_THERM_HYST));
    else
      cond[`ALSR_BIT_THERM] = (conv.die_temp >= `ALSR_THERM_TRIP);
    en_vec[14:11] = 4'hF;
    en_vec[`ALSR_BIT_LT_LO] = ctrl_q[`ALSR_CTRL_ONCHIP_SENSOR_ENABLE];
    en_vec[`ALSR_BIT_LT_HI] = ctrl_q[`ALSR_CTRL_ONCHIP_SENSOR_ENABLE];
    en_vec[`ALSR_BIT_R1_LO] = ctrl_q[`ALSR_CTRL_EN_R1];
    en_vec[`ALSR_BIT_R1_HI] = ctrl_q[`ALSR_CTRL_EN_R1];
    en_vec[`ALSR_BIT_R2_LO] = ctrl_q[`ALSR_CTRL_EN_R2];
    en_vec[`ALSR_BIT_R2_HI] = ctrl_q[`ALSR_CTRL_EN_R2];
    en_vec[`ALSR_BIT_R1_FAIL] = ctrl_q[`ALSR_CTRL_EN_R1];
    en_vec[`ALSR_BIT_R2_FAIL] = ctrl_q[`ALSR_CTRL_EN_R2];
    en_vec[`ALSR_BIT_THERM] = ctrl_q[`ALSR_CTRL_ONCHIP_SENSOR_ENABLE];
  end

  ////////////////////////////////////////////////////////////////
  // One filtered flag per live bit; reserved bits stay zero
  assign flags[15] = 1'b0;
  assign flags[1:0] = 2'b00;

  genvar gi;
  generate
    for (gi = 2; gi <= 14; gi++)
    begin : g_flag
      alsr_flag_cell #(
        .CONSEC_N(CONSEC_N)
      ) u_cell (
        .clk_sys(clk_sys),
        .rst(any_rst),
        .ce(ce),
        .check(conv.done),
        .out_of_range(cond[gi]),
        .enable(en_vec[gi]),
        .hold_dis(hold_dis),
        .read_clr(read_clr),
        .flag(flags[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Read data and alarm pin, both registered
  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
    begin
      rdata_q <= `ALSR_RESET_VALUE;
      alarm_n_q <= 1'b1;
    end
    else if (ce)
    begin
      alarm_n_q <= ~|(flags & mask_q);
      if (req.rd)
      begin
        if (req.addr == `ALSR_ADDR_STATUS)
          rdata_q <= flags & `ALSR_LIVE_MASK;
        else if (req.addr == `ALSR_ADDR_CTRL)
          rdata_q <= ctrl_q;
        else if (req.addr == `ALSR_ADDR_MASK)
          rdata_q <= mask_q;
        else
          rdata_q <= 16'h0000;
      end
      else
        rdata_q <= 16'h0000;
    end
  end

  assign rdata = rdata_q;
  assign alarm_n = alarm_n_q;
endmodule // alsr_status

//--- alsr_status_sva.sv
// Purpose: Port-level checks for the alarm status register
// Assumes: ce held high by the bench
// Notes: Shadow mask follows the port writes; shadow control keeps bit 0 as written and ORs in each enable bit
`timescale 1ns/1ns
module alsr_status_sva
  import alsr_pkg::*;
#(
  parameter int CONSEC_N = 4
)
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Clock enable
  input wire logic soft_rst, // Soft reset
  input wire alsr_req_s req, // Register port
  input wire alsr_conv_s conv, // Conversions
  input wire logic remote1_fail, // Fault one
  input wire logic remote2_fail, // Fault two
  input wire logic [15:0] rdata, // Read data
  input wire logic alarm_n // Alarm pin
);
  logic srst;
  logic st_rd;
  logic [3:0] ctrl_q;
  logic [15:0] mask_q;
  logic [2:0] dcnt_q;
  logic [15:0] dis_m;
  assign srst = rst || soft_rst;
  assign st_rd = req.rd && req.addr == 8'h4F;
  assign dis_m = {5'h00, {2{~ctrl_q[1]}}, {2{~ctrl_q[2]}}, {2{~ctrl_q[3]}}, ~ctrl_q[2],
    ~ctrl_q[3], ~ctrl_q[1], 2'h0};
  // Enables are sticky: a channel never enabled can never show a flag
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_q <= 4'h0;
      mask_q <= 16'h0000;
    end
    else if (req.wr && req.addr == 8'h4E)
      ctrl_q <= {ctrl_q[3:1] | req.wdata[3:1], req.wdata[0]};
    else if (req.wr && req.addr == 8'h4D)
      mask_q <= req.wdata;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      dcnt_q <= 3'h0;
    else if (conv.done && dcnt_q != 3'h7)
      dcnt_q <= dcnt_q + 3'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_clear_rd;
    st_rd && !ctrl_q[0] && !conv.done ##1 st_rd;
  endsequence
  property p_reset; $fell(rst) |-> rdata == 16'h0000 && alarm_n; endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
  property p_idle; !req.rd |=> rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_unmap; req.rd && req.addr < 8'h4D |=> rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rsv; (rdata & 16'h8003) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_filter; st_rd && dcnt_q < CONSEC_N |=> (rdata & 16'h7FF8) == 16'h0000; endproperty
  a_filter: assert property (p_filter) else $error("flag before N results");
  property p_clear; s_clear_rd |=> rdata == 16'h0000; endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");
  property p_dis; st_rd |=> (rdata & $past(dis_m)) == 16'h0000; endproperty
  a_dis: assert property (p_dis) else $error("disabled sensor flagged");
  property p_mask; $past(mask_q, 2) == 16'h0000 && $past(mask_q) == 16'h0000 |-> alarm_n; endproperty
  a_mask: assert property (p_mask) else $error("masked alarm drove pin");
endmodule // alsr_status_sva
bind alsr_status alsr_status_sva #(.CONSEC_N(CONSEC_N)) u_sva (.clk_sys(clk_sys), .rst(rst),
  .ce(ce), .soft_rst(soft_rst), .req(req), .conv(conv), .remote1_fail(remote1_fail),
  .remote2_fail(remote2_fail), .rdata(rdata), .alarm_n(alarm_n));

//--- alsr_status_tb.sv
// Purpose: Random and corner checks of the alarm status register
// Assumes: ce stays high; CONSEC_N at its default of 4
// Notes: Expected flags come from ex() in the random loop and from constants in the corner checks, never from the design
`timescale 1ns/1ns
module alsr_status_tb
  import alsr_pkg::*;
;
  logic clk_sys, rst, ce, soft_rst, remote1_fail, remote2_fail, alarm_n, hot;
  alsr_req_s req;
  alsr_conv_s conv;
  logic [15:0] rdata, m, e;
  logic [9:0] r;
  logic [2:0] en;
  logic [1:0] f;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  alsr_status uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .soft_rst(soft_rst), .req(req),
    .conv(conv), .remote1_fail(remote1_fail), .remote2_fail(remote2_fail), .rdata(rdata),
    .alarm_n(alarm_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] ex(logic [9:0] rr, logic [1:0] ff, logic hh, logic [2:0] ee);
    return {1'b0, rr, ff, hh, 2'h0} & ~({16{!ee[0]}} & 16'h0604 | {16{!ee[1]}} & 16'h0190
      | {16{!ee[2]}} & 16'h0068);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) req <= '0;
  endtask
  // Two reads in a row when n is 2: the second shows what the first cleared
  task automatic rd(input logic [7:0] a, input logic [15:0] e1, input logic [15:0] e2, input int n);
    @(posedge clk_sys) req <= '{a, 16'h0000, 1'b0, 1'b1};
    if (n > 1)
    begin
      @(posedge clk_sys) #1 chk(rdata, e1, "rdata");
    end
    @(posedge clk_sys) req <= '0;
    #1 chk(rdata, (n > 1) ? e2 : e1, "rdata");
  endtask
  task automatic cv(input int n, input logic [9:0] rr, input logic [1:0] ff, input logic [15:0] t);
    {remote1_fail, remote2_fail} <= ff;
    repeat (n)
    begin
      @(posedge clk_sys) conv <= '{1'b1, {rr, 4'h0}, t};
      @(posedge clk_sys) conv.done <= 1'b0;
    end
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    {rst, ce, soft_rst, remote1_fail, remote2_fail} = 5'h18;
    req = '0;
    conv = '0;
    void'($urandom(84));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    cv(3, 10'h3C0, 2'h0, 16'h0800);
    cv(1, 10'h000, 2'h0, 16'h0800);
    cv(3, 10'h3C0, 2'h0, 16'h0800);
    rd(8'h4F, 16'h0000, 16'h0000, 1);
    cv(1, 10'h3C0, 2'h0, 16'h0800);
    rd(8'h4F, 16'h7800, 16'h0000, 2);
    cv(1, 10'h3C0, 2'h0, 16'h0800);
    wr(8'h4F, 16'hFFFF);
    cv(1, 10'h000, 2'h0, 16'h0800);
    rd(8'h4F, 16'h7800, 16'h0000, 2);
    wr(8'h4E, 16'h0001);
    cv(4, 10'h3C0, 2'h0, 16'h0800);
    cv(1, 10'h000, 2'h0, 16'h0800);
    rd(8'h4F, 16'h0000, 16'h0000, 1);
    for (int i = 0; i < 24; i++)
    begin
      en = 3'($urandom) | {3{i == 0}};
      m = 16'($urandom) | {16{i == 0}};
      r = 10'($urandom) | {10{i == 0}};
      f = 2'($urandom) | {2{i == 0}};
      hot = 1'($urandom) | (i == 0);
      wr(8'h4E, {12'h000, en, 1'b0});
      wr(8'h4D, m);
      cv(4, r, f, hot ? 16'h0960 + 16'(i) : 16'h0800);
      e = ex(r, f, hot, en);
      @(posedge clk_sys) #1 chk({15'h0000, alarm_n}, {15'h0000, ~|(e & m)}, "alarm_n");
      rd(8'h4F, e, 16'h0000, 1);
    end
    cv(4, 10'h3FF, 2'h3, 16'h0960);
    @(posedge clk_sys) soft_rst <= 1'b1;
    @(posedge clk_sys) soft_rst <= 1'b0;
    rd(8'h4F, 16'h0000, 16'h0000, 1);
    rd(8'h10, 16'h0000, 16'h0000, 1);
    complete_run();
  end
endmodule // alsr_status_tb
